// file: include/spfc_cfg.svh
// Offsets, field positions, patterns and timing counts for self-program flash control
`ifndef SPFC_CFG_SVH
`define SPFC_CFG_SVH

`define SPFC_CSR_DATA_OFS   8'h57
`define SPFC_IO_BIAS        8'h20
`define SPFC_CSR_IO_OFS     (`SPFC_CSR_DATA_OFS - `SPFC_IO_BIAS)
`define SPFC_CSR_RESET      8'h00

`define SPFC_B_IE           7
`define SPFC_B_BUSY         6
`define SPFC_B_EN           0

`define SPFC_CMD_LOAD       6'h01
`define SPFC_CMD_ERASE      6'h03
`define SPFC_CMD_WRITE      6'h05
`define SPFC_CMD_LOCK       6'h09
`define SPFC_CMD_REEN       6'h11
`define SPFC_CMD_SIG        6'h21
`define SPFC_CMD_NONE       6'h00

`define SPFC_SPM_WIN        3'h4
`define SPFC_LPM_WIN        3'h3
`define SPFC_WIN_FIRST      3'h1

`define SPFC_PC_W           13
`define SPFC_PAGE_MSB       13
`define SPFC_PAGE_LSB       7
`define SPFC_WORD_MSB       6
`define SPFC_WORD_LSB       1
`define SPFC_RWW_PAGES      7'h70

`define SPFC_BOOT_128       13'h1F80
`define SPFC_BOOT_256       13'h1F00
`define SPFC_BOOT_512       13'h1E00
`define SPFC_BOOT_1024      13'h1C00

`define SPFC_CLK_PERIOD_NS  25
`define SPFC_PROG_MIN_NS    3200000
`define SPFC_PROG_MAX_NS    3400000
`define SPFC_TMR_W          17
`define SPFC_PROG_CYCLES    ((`SPFC_PROG_MIN_NS + `SPFC_CLK_PERIOD_NS - 1) / `SPFC_CLK_PERIOD_NS)

`endif

// file: include/spfc_pkg.sv
// Types for self-program flash control
package spfc_pkg;

   typedef enum logic [2:0] {
      SPFC_ST_IDLE  = 3'b001,
      SPFC_ST_ARMED = 3'b010,
      SPFC_ST_PROG  = 3'b100
   } spfc_state_t;

   typedef struct packed {
      spfc_state_t  state;
      logic [7:0]   csr;
      logic [2:0]   win;
      logic         dirty;
      logic [6:0]   page;
      logic         stalling_region;
      logic [7:0]   rdata;
      logic         irq;
      logic         stall;
      logic         erase_go;
      logic         write_go;
      logic         lock_go;
      logic [7:0]   lock_data;
      logic         pbuf_we;
      logic         pbuf_clear;
      logic [5:0]   pbuf_word;
      logic [15:0]  pbuf_data;
      logic         lpm_valid;
      logic [7:0]   lpm_data;
      logic [12:0]  boot_start;
      logic         tmr_start;
   } spfc_regs_t;

   typedef struct packed {
      logic [16:0]  cnt;
      logic         run;
      logic         done;
   } spfc_tmr_t;

endpackage

// file: hdl/spfc_prog_timer.sv
// Programming-time counter for erase, page write and lock programming
`timescale 1ns/1ps
`default_nettype none
`include "spfc_cfg.svh"

module spfc_prog_timer #(
   parameter logic [16:0] CYCLES = 17'(`SPFC_PROG_CYCLES)
) (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic start,
   output logic      done
);
   import spfc_pkg::*;

   spfc_tmr_t t_r;
   spfc_tmr_t t_nxt;

   always_comb begin
      t_nxt      = t_r;
      t_nxt.done = 1'b0;
      if (start) begin
         t_nxt.run = 1'b1;
         t_nxt.cnt = CYCLES - 17'h00001;
      end else if (t_r.run) begin
         if (t_r.cnt == 17'h00000) begin
            t_nxt.run  = 1'b0;
            t_nxt.done = 1'b1;
         end else begin
            t_nxt.cnt = t_r.cnt - 17'h00001;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         t_r <= '0;
      end else begin
         t_r <= t_nxt;
      end
   end

   assign done = t_r.done;

endmodule // spfc_prog_timer

`default_nettype wire

// file: hdl/spfc_ctrl.sv
// Self-program flash control: command arming, page buffer, erase/write/lock sequencing
`timescale 1ns/1ps
`default_nettype none
`include "spfc_cfg.svh"

module spfc_ctrl #(
   parameter logic [16:0] PROG_CYCLES = 17'(`SPFC_PROG_CYCLES)
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic        reg_io_space,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   input  wire logic        spm_strobe,
   input  wire logic        lpm_strobe,
   input  wire logic [15:0] z_ptr,
   input  wire logic [15:0] data_register_pair,
   input  wire logic        global_int_en,
   input  wire logic [1:0]  boot_size_fuse,
   input  wire logic [7:0]  lock_bits_in,
   input  wire logic [7:0]  fuse_bits_in,
   input  wire logic [7:0]  sig_row_byte,
   output logic             ready_irq,
   output logic             rww_region_busy,
   output logic             cpu_stall,
   output logic      [12:0] boot_start,
   output logic             flash_erase_go,
   output logic             flash_write_go,
   output logic      [6:0]  page_select_field,
   output logic             lock_prog_go,
   output logic      [7:0]  lock_prog_data,
   output logic             pbuf_we,
   output logic             pbuf_clear,
   output logic      [5:0]  word_select_field,
   output logic      [15:0] pbuf_data,
   output logic             lpm_valid,
   output logic      [7:0]  lpm_data
);
   import spfc_pkg::*;

   spfc_regs_t s_r;
   spfc_regs_t s_nxt;
   logic       tmr_done;
   logic       addr_hit;
   logic       wr_hit;
   logic [5:0] wr_cmd;
   logic       wr_legal;
   logic [5:0] cur_cmd;
   logic [6:0] z_page;

   spfc_prog_timer #(
      .CYCLES (PROG_CYCLES)
   ) u_timer (
      .clk   (clk),
      .rst_b (rst_b),
      .start (s_r.tmr_start),
      .done  (tmr_done)
   );

   // Data-space or I/O-space decode of the single register
   assign addr_hit = reg_io_space ? (reg_addr == `SPFC_CSR_IO_OFS)
                                  : (reg_addr == `SPFC_CSR_DATA_OFS);
   assign wr_hit   = reg_wr && addr_hit;
   assign wr_cmd   = reg_wdata[5:0];
   assign cur_cmd  = s_r.csr[5:0];
   assign z_page   = z_ptr[`SPFC_PAGE_MSB:`SPFC_PAGE_LSB];

   assign wr_legal = (wr_cmd == `SPFC_CMD_LOAD)  || (wr_cmd == `SPFC_CMD_ERASE) ||
                     (wr_cmd == `SPFC_CMD_WRITE) || (wr_cmd == `SPFC_CMD_LOCK) ||
                     (wr_cmd == `SPFC_CMD_REEN)  || (wr_cmd == `SPFC_CMD_SIG);

   always_comb begin
      s_nxt            = s_r;
      s_nxt.erase_go   = 1'b0;
      s_nxt.write_go   = 1'b0;
      s_nxt.lock_go    = 1'b0;
      s_nxt.pbuf_we    = 1'b0;
      s_nxt.pbuf_clear = 1'b0;
      s_nxt.lpm_valid  = 1'b0;
      s_nxt.tmr_start  = 1'b0;
      s_nxt.rdata      = (reg_rd && addr_hit) ? s_r.csr : 8'h00;
      s_nxt.irq        = s_r.csr[`SPFC_B_IE] && global_int_en && !s_r.csr[`SPFC_B_EN];
      s_nxt.stall      = (s_r.state == SPFC_ST_PROG) && s_r.stalling_region && !tmr_done;

      unique case (boot_size_fuse)
         2'b11: s_nxt.boot_start = `SPFC_BOOT_128;
         2'b10: s_nxt.boot_start = `SPFC_BOOT_256;
         2'b01: s_nxt.boot_start = `SPFC_BOOT_512;
         2'b00: s_nxt.boot_start = `SPFC_BOOT_1024;
      endcase

      if (wr_hit) begin
         s_nxt.csr[`SPFC_B_IE] = reg_wdata[`SPFC_B_IE];
      end

      unique case (s_r.state)
         SPFC_ST_IDLE: begin
            if (wr_hit && wr_legal) begin
               s_nxt.csr[5:0] = wr_cmd;
               s_nxt.state    = SPFC_ST_ARMED;
               s_nxt.win      = `SPFC_WIN_FIRST;
               if (wr_cmd == `SPFC_CMD_REEN && s_r.dirty) begin
                  s_nxt.pbuf_clear = 1'b1;
                  s_nxt.dirty      = 1'b0;
               end
            end
         end

         SPFC_ST_ARMED: begin
            if (spm_strobe) begin
               s_nxt.csr[5:0] = `SPFC_CMD_NONE;
               s_nxt.state    = SPFC_ST_IDLE;
               unique case (cur_cmd)
                  `SPFC_CMD_LOAD: begin
                     s_nxt.pbuf_we   = 1'b1;
                     s_nxt.pbuf_word = z_ptr[`SPFC_WORD_MSB:`SPFC_WORD_LSB];
                     s_nxt.pbuf_data = data_register_pair;
                     s_nxt.dirty     = 1'b1;
                     s_nxt.csr[`SPFC_B_BUSY] = 1'b0;
                  end
                  `SPFC_CMD_ERASE, `SPFC_CMD_WRITE: begin
                     s_nxt.csr[5:0] = cur_cmd;
                     s_nxt.state    = SPFC_ST_PROG;
                     s_nxt.tmr_start = 1'b1;
                     s_nxt.page     = z_page;
                     s_nxt.stalling_region     = (z_page >= `SPFC_RWW_PAGES);
                     s_nxt.erase_go = (cur_cmd == `SPFC_CMD_ERASE);
                     s_nxt.write_go = (cur_cmd == `SPFC_CMD_WRITE);
                     if (z_page < `SPFC_RWW_PAGES) begin
                        s_nxt.csr[`SPFC_B_BUSY] = 1'b1;
                     end
                     if (cur_cmd == `SPFC_CMD_WRITE) begin
                        s_nxt.dirty = 1'b0;
                     end
                  end
                  `SPFC_CMD_LOCK: begin
                     s_nxt.csr[5:0]   = cur_cmd;
                     s_nxt.state      = SPFC_ST_PROG;
                     s_nxt.tmr_start  = 1'b1;
                     s_nxt.stalling_region       = 1'b0;
                     s_nxt.lock_go    = 1'b1;
                     s_nxt.lock_data  = data_register_pair[7:0];
                  end
                  `SPFC_CMD_REEN: begin
                     s_nxt.csr[`SPFC_B_BUSY] = 1'b0;
                  end
                  default: begin
                     // Signature arm: store is a no-op
                     s_nxt.csr[5:0] = `SPFC_CMD_NONE;
                  end
               endcase
            end else begin
               if (lpm_strobe && s_r.win <= `SPFC_LPM_WIN) begin
                  if (cur_cmd == `SPFC_CMD_SIG) begin
                     s_nxt.lpm_valid = 1'b1;
                     s_nxt.lpm_data  = sig_row_byte;
                  end else if (cur_cmd == `SPFC_CMD_LOCK) begin
                     s_nxt.lpm_valid = 1'b1;
                     s_nxt.lpm_data  = z_ptr[0] ? fuse_bits_in : lock_bits_in;
                  end
               end
               if (s_r.win == `SPFC_SPM_WIN) begin
                  s_nxt.csr[5:0] = `SPFC_CMD_NONE;
                  s_nxt.state    = SPFC_ST_IDLE;
               end else begin
                  s_nxt.win = s_r.win + 3'h1;
               end
               // A fresh legal write re-arms the window
               if (wr_hit && wr_legal) begin
                  s_nxt.csr[5:0] = wr_cmd;
                  s_nxt.state    = SPFC_ST_ARMED;
                  s_nxt.win      = `SPFC_WIN_FIRST;
                  if (wr_cmd == `SPFC_CMD_REEN && s_r.dirty) begin
                     s_nxt.pbuf_clear = 1'b1;
                     s_nxt.dirty      = 1'b0;
                  end
               end
            end
         end

         SPFC_ST_PROG: begin
            // Command bits locked; re-enable has no effect here
            if (tmr_done) begin
               s_nxt.csr[5:0] = `SPFC_CMD_NONE;
               s_nxt.state    = SPFC_ST_IDLE;
               s_nxt.stalling_region     = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r       <= '0;
         s_r.state <= SPFC_ST_IDLE;
         s_r.csr   <= `SPFC_CSR_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata         = s_r.rdata;
   assign ready_irq         = s_r.irq;
   assign rww_region_busy   = s_r.csr[`SPFC_B_BUSY];
   assign cpu_stall         = s_r.stall;
   assign boot_start        = s_r.boot_start;
   assign flash_erase_go    = s_r.erase_go;
   assign flash_write_go    = s_r.write_go;
   assign page_select_field = s_r.page;
   assign lock_prog_go      = s_r.lock_go;
   assign lock_prog_data    = s_r.lock_data;
   assign pbuf_we           = s_r.pbuf_we;
   assign pbuf_clear        = s_r.pbuf_clear;
   assign word_select_field = s_r.pbuf_word;
   assign pbuf_data         = s_r.pbuf_data;
   assign lpm_valid         = s_r.lpm_valid;
   assign lpm_data          = s_r.lpm_data;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_irq_level: assert property ((s_r.csr[7] && global_int_en && !s_r.csr[0]) |=> ready_irq)
      else $error("ready interrupt not raised");

   a_irq_quiet: assert property (!(s_r.csr[7] && global_int_en && !s_r.csr[0]) |=> !ready_irq)
      else $error("ready interrupt raised without cause");

   a_window_expire: assert property ((s_r.state == SPFC_ST_ARMED && s_r.win == 3'h4
                                      && !spm_strobe && !wr_hit) |=> !s_r.csr[0])
      else $error("enable not cleared at window end");

   a_window_start: assert property ((wr_hit && wr_legal && s_r.state == SPFC_ST_IDLE)
                                    |=> s_r.state == SPFC_ST_ARMED && s_r.win == 3'h1)
      else $error("legal write did not open the window");

   a_busy_on_rww: assert property ((s_r.state == SPFC_ST_ARMED && spm_strobe
                                    && (cur_cmd == 6'h03 || cur_cmd == 6'h05)
                                    && z_ptr[13:7] < 7'h70) |=> rww_region_busy)
      else $error("busy not set on concurrent-region programming");

   a_busy_load_clr: assert property ((s_r.state == SPFC_ST_ARMED && spm_strobe
                                      && cur_cmd == 6'h01) |=> !rww_region_busy && pbuf_we)
      else $error("buffer load did not clear busy");

   a_reen_clr_busy: assert property ((s_r.state == SPFC_ST_ARMED && spm_strobe
                                      && cur_cmd == 6'h11) |=> !rww_region_busy)
      else $error("re-enable did not clear busy");

   a_reen_buf_drop: assert property ((wr_hit && wr_cmd == 6'h11 && s_r.dirty
                                      && s_r.state == SPFC_ST_IDLE) |=> pbuf_clear)
      else $error("re-enable write kept loaded buffer data");

   a_stall_only_prog: assert property (cpu_stall |-> $past(s_r.state) == SPFC_ST_PROG
                                       && $past(s_r.stalling_region))
      else $error("stall outside stalling-region programming");

   a_stalling_region_stall: assert property ((flash_erase_go || flash_write_go) && s_r.stalling_region
                                  |=> cpu_stall [*8])
      else $error("core not stalled during stalling-region programming");

   a_pattern_reject: assert property ((wr_hit && !wr_legal && s_r.state == SPFC_ST_IDLE)
                                      |=> s_r.csr[5:0] == 6'h00)
      else $error("illegal pattern took effect");

   a_prog_cmd_lock: assert property ((s_r.state == SPFC_ST_PROG && !tmr_done)
                                     |=> $stable(cur_cmd) && s_r.csr[0])
      else $error("command bits changed during programming");

   a_buf_word_map: assert property (pbuf_we |-> word_select_field == $past(z_ptr[6:1])
                                    && pbuf_data == $past(data_register_pair))
      else $error("buffer word or data mismatch");

   a_lock_data_src: assert property (lock_prog_go
                                     |-> lock_prog_data == $past(data_register_pair[7:0])
                                     ##1 s_r.csr[0] [*2])
      else $error("lock data or held enable wrong");

   a_lpm_lock_read: assert property ((s_r.state == SPFC_ST_ARMED && cur_cmd == 6'h09
                                      && !spm_strobe && lpm_strobe && s_r.win <= 3'h3)
                                     |=> lpm_valid && lpm_data == ($past(z_ptr[0]) ?
                                         $past(fuse_bits_in) : $past(lock_bits_in)))
      else $error("lock or fuse read wrong");

   a_sig_store_none: assert property ((s_r.state == SPFC_ST_ARMED && spm_strobe
                                       && cur_cmd == 6'h21)
                                      |=> !flash_erase_go && !flash_write_go
                                          && !lock_prog_go && !pbuf_we)
      else $error("signature arm store had an effect");

   a_erase_page_src: assert property ((s_r.state == SPFC_ST_ARMED && spm_strobe
                                       && cur_cmd == 6'h03)
                                      |=> flash_erase_go
                                          && page_select_field == $past(z_ptr[13:7]))
      else $error("erase not started on pointer page");

   a_write_go_only: assert property ((s_r.state == SPFC_ST_ARMED && spm_strobe
                                      && cur_cmd == 6'h05) |=> flash_write_go && !flash_erase_go)
      else $error("page write not started");

   a_prog_hold_busy: assert property ((s_r.state == SPFC_ST_PROG && rww_region_busy)
                                      |=> rww_region_busy)
      else $error("busy dropped during programming");

   a_reg_read_data: assert property (reg_rd && addr_hit |=> reg_rdata == $past(s_r.csr))
      else $error("register read data wrong");

   a_boot_map: assert property ($past(rst_b) |-> boot_start ==
                                ($past(boot_size_fuse) == 2'b11 ? 13'h1F80 :
                                 $past(boot_size_fuse) == 2'b10 ? 13'h1F00 :
                                 $past(boot_size_fuse) == 2'b01 ? 13'h1E00 : 13'h1C00))
      else $error("boot start mismatch");

   c_page_erase: cover property (flash_erase_go);
   c_buf_load:   cover property (pbuf_we);
   c_lock_read:  cover property (lpm_valid && s_r.csr[3]);
   c_timeout:    cover property (s_r.state == SPFC_ST_ARMED && s_r.win == 3'h4 && !spm_strobe);
   c_stall_span: cover property (cpu_stall);

endmodule // spfc_ctrl

`default_nettype wire

// file: bench/spfc_core_model.sv
// Processor-core model: register accesses and store/load program strobes
`timescale 1ns/1ps
`default_nettype none
module spfc_core_model (
   input  wire logic        clk,
   input  wire logic [7:0]  reg_rdata,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic             reg_io_space,
   output logic      [7:0]  reg_addr,
   output logic      [7:0]  reg_wdata,
   output logic             spm_strobe,
   output logic             lpm_strobe,
   output logic      [15:0] z_ptr,
   output logic      [15:0] data_register_pair
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_io_space = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      spm_strobe = 1'b0;
      lpm_strobe = 1'b0;
      z_ptr = 16'h0000;
      data_register_pair = 16'h0000;
   end

   task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr       <= 1'b1;
      reg_io_space <= io;
      reg_addr     <= a;
      reg_wdata    <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic io, input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd       <= 1'b1;
      reg_io_space <= io;
      reg_addr     <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
   endtask

   // Strobe after gap idle cycles; returns at the sampling edge
   task automatic spm(input int gap, input logic [15:0] z, input logic [15:0] d);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      spm_strobe         <= 1'b1;
      z_ptr              <= {z[15:1], 1'b0};
      data_register_pair <= d;
      @(posedge clk);
      spm_strobe         <= 1'b0;
      z_ptr              <= ~z;
      data_register_pair <= ~d;
   endtask

   task automatic lpm(input logic [15:0] z);
      @(posedge clk);
      lpm_strobe <= 1'b1;
      z_ptr      <= z;
      @(posedge clk);
      lpm_strobe <= 1'b0;
      z_ptr      <= ~z;
   endtask

   task automatic wait_idle(output logic ok);
      logic [7:0] d;
      ok = 1'b0;
      for (int i = 0; i < 40 && !ok; i++) begin
         rd(1'b0, 8'h57, d);
         ok = !d[0];
      end
   endtask
endmodule // spfc_core_model
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking testbench for self-program flash control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk, rst_b, gie, reg_wr, reg_rd, io, spm_s, lpm_s;
   logic [1:0]  fuse;
   logic [7:0]  addr, wdata, rdata, lockb, fuseb, sigb, lpm_data, lock_data;
   logic [15:0] z, drp, pbuf_data;
   logic        irq, busy, stall, ers_go, wr_go, lock_go, pb_we, pb_clr, lpm_v;
   logic [12:0] boot_start;
   logic [6:0]  page;
   logic [5:0]  word;
   int          fail_count = 0;
   int          checks_done = 0;
   logic [7:0]  d;

   spfc_core_model core (.clk(clk), .reg_rdata(rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_io_space(io), .reg_addr(addr), .reg_wdata(wdata), .spm_strobe(spm_s),
      .lpm_strobe(lpm_s), .z_ptr(z), .data_register_pair(drp));

   spfc_ctrl #(.PROG_CYCLES(17'h00014)) dut (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_io_space(io), .reg_addr(addr), .reg_wdata(wdata),
      .reg_rdata(rdata), .spm_strobe(spm_s), .lpm_strobe(lpm_s), .z_ptr(z),
      .data_register_pair(drp), .global_int_en(gie), .boot_size_fuse(fuse),
      .lock_bits_in(lockb), .fuse_bits_in(fuseb), .sig_row_byte(sigb), .ready_irq(irq),
      .rww_region_busy(busy), .cpu_stall(stall), .boot_start(boot_start),
      .flash_erase_go(ers_go), .flash_write_go(wr_go), .page_select_field(page),
      .lock_prog_go(lock_go), .lock_prog_data(lock_data), .pbuf_we(pb_we),
      .pbuf_clear(pb_clr), .word_select_field(word), .pbuf_data(pbuf_data),
      .lpm_valid(lpm_v), .lpm_data(lpm_data));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic idle();
      logic ok;
      core.wait_idle(ok);
      if (!ok) begin
         fail_count++;
         print_verdict();
      end
   endtask

   // Go pulses seen one cycle after the strobe: erase, write, lock, load
   task automatic pulses(input logic [3:0] e);
      #1 chk(16'({ers_go, wr_go, lock_go, pb_we}), 16'(e));
   endtask

   task automatic t_reset();
      core.rd(1'b0, 8'h57, d);
      chk(16'(d), 16'h0000);
      core.rd(1'b0, 8'h58, d);
      chk(16'(d), 16'h0000);
      for (int f = 0; f < 4; f++) begin
         @(posedge clk);
         fuse <= 2'(f);
         repeat (2) @(posedge clk);
         #1 chk(16'(boot_start), 16'h2000 - (16'h0080 << (3 - f)));
      end
   endtask

   task automatic t_irq();
      @(posedge clk);
      gie <= 1'b1;
      core.wr(1'b1, 8'h37, 8'h80);
      repeat (2) @(posedge clk);
      #1 chk(16'(irq), 16'h0001);
      core.rd(1'b0, 8'h57, d);
      chk(16'(d), 16'h0080);
      core.wr(1'b0, 8'h57, 8'h81);
      repeat (2) @(posedge clk);
      #1 chk(16'(irq), 16'h0000);
      repeat (8) @(posedge clk);
      #1 chk(16'(irq), 16'h0001);
      @(posedge clk);
      gie <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(16'(irq), 16'h0000);
      core.wr(1'b0, 8'h57, 8'h00);
   endtask

   task automatic t_window();
      core.wr(1'b0, 8'h57, 8'h01);
      core.spm(2, 16'h0000, 16'h1111);
      pulses(4'b0001);
      idle();
      core.wr(1'b0, 8'h57, 8'h01);
      core.spm(3, 16'h0000, 16'h2222);
      pulses(4'b0000);
      for (int i = 0; i < 3; i++) begin
         core.wr(1'b0, 8'h57, i == 0 ? 8'h07 : (i == 1 ? 8'h02 : 8'h0B));
         core.rd(1'b0, 8'h57, d);
         chk(16'(d), 16'h0000);
      end
   endtask

   task automatic t_prog(input logic [7:0] cmd, input logic [6:0] pg, input logic stalling_region);
      core.wr(1'b0, 8'h57, cmd);
      core.spm(0, {2'b00, pg, 7'h00}, 16'h1234);
      pulses({cmd == 8'h03, cmd == 8'h05, 2'b00});
      chk(16'(page), 16'(pg));
      @(posedge clk);
      #1 chk(16'({stall, busy}), 16'({stalling_region, !stalling_region}));
      core.rd(1'b0, 8'h57, d);
      chk(16'(d[5:0]), 16'(cmd[5:0]));
      core.wr(1'b0, 8'h57, 8'h11);
      core.spm(0, 16'h0000, 16'h0000);
      idle();
      chk(16'({stall, busy}), 16'({1'b0, !stalling_region}));
   endtask

   task automatic t_load_reen();
      core.wr(1'b0, 8'h57, 8'h01);
      core.spm(0, 16'hC000 | (16'h0025 << 1) | 16'h0001, 16'hBEEF);
      pulses(4'b0001);
      chk(16'(word), 16'h0025);
      chk(pbuf_data, 16'hBEEF);
      chk(16'(busy), 16'h0000);
      core.wr(1'b0, 8'h57, 8'h11);
      #1 chk(16'(pb_clr), 16'h0001);
      core.spm(0, 16'h0000, 16'h0000);
      idle();
   endtask

   task automatic t_lock();
      lockb <= 8'h3C;
      fuseb <= 8'h5A;
      sigb  <= 8'h96;
      for (int i = 0; i < 3; i++) begin
         core.wr(1'b0, 8'h57, i == 2 ? 8'h21 : 8'h09);
         core.lpm(16'(i == 1));
         #1 chk(16'({lpm_v, lpm_data}), i == 0 ? 16'h013C : (i == 1 ? 16'h015A : 16'h0196));
         idle();
      end
      core.wr(1'b0, 8'h57, 8'h21);
      core.spm(0, 16'h0000, 16'h7777);
      pulses(4'b0000);
      idle();
      core.wr(1'b0, 8'h57, 8'h09);
      core.spm(0, 16'hFFFE, 16'hA5C3);
      pulses(4'b0010);
      chk(16'(lock_data), 16'h00C3);
      idle();
      core.rd(1'b1, 8'h37, d);
      chk(16'(d), 16'h0000);
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      repeat (50000) @(posedge clk);
      fail_count++;
      print_verdict();
   end

   initial begin
      rst_b = 1'b0;
      gie = 1'b0;
      fuse = 2'b11;
      lockb = 8'hFF;
      fuseb = 8'hFF;
      sigb = 8'h00;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_irq();
      t_window();
      t_prog(8'h03, 7'd111, 1'b0);
      core.wr(1'b0, 8'h57, 8'h11);
      core.spm(0, 16'h0000, 16'h0000);
      #1 @(posedge clk);
      #1 chk(16'(busy), 16'h0000);
      idle();
      t_prog(8'h05, 7'd112, 1'b1);
      t_prog(8'h03, 7'd5, 1'b0);
      t_load_reen();
      t_lock();
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
